// *** testbench/bus_peer.sv ***
// far-side model: another master sharing the two-wire bus
// assumes the bench resolves the open-drain wires with pull-ups
`timescale 1ns/1ps
module bus_peer (
  // link clock
  input wire logic link_clk,
  // resolved wire levels
  input wire logic scl,
  input wire logic sda,
  // pull-downs onto the wires
  output logic scl_low,
  output logic sda_low
);
  // =====================================
  // wire driving
  initial begin
    scl_low = 1'b0;
    sda_low = 1'b0;
  end
  // four link cycles apart so events never merge in the crossing
  task automatic gap();
    repeat (4) @(posedge link_clk);
    #5;
  endtask
  // a pull-down is only started on an idle bus; release is always legal
  task automatic drive_sda(input logic low);
    gap();
    if (!low || (scl && sda)) begin
      sda_low = low;
    end
    gap();
  endtask
endmodule

// *** testbench/i2c_multi_master_arbitration_bench.sv ***
// self-checking bench for the bus supervisor
// assumes bus_peer as the other master and pull-ups on both wires
`timescale 1ns/1ps
`include "arb_defines.svh"
module i2c_multi_master_arbitration_bench;
  import arb_pkg::*;
  // =====================================
  // signals
  logic clock, rst, link_clk, port_enable_bit, event_enable, event_clear;
  logic collision_clear, master_go, master_done, sda_check, sda_low_req;
  logic scl_low_req, byte_done, ack_done, serial_event_flag, event_irq;
  logic bus_collision_flag, bus_free, master_active, scl, sda;
  logic scl_out, scl_oe_n, sda_out, sda_oe_n, peer_scl, peer_sda;
  logic [`STAT_W-1:0] serial_status_reg;
  op_phase_e phase, lost_phase;
  int miscompares = 0;
  int num_checks = 0;
  assign scl = (scl_oe_n | scl_out) & ~peer_scl;
  assign sda = (sda_oe_n | sda_out) & ~peer_sda;
  bus_supervisor DUT (.clock, .rst, .link_clk, .port_enable_bit,
    .event_enable, .event_clear, .collision_clear, .master_go,
    .master_done, .phase, .sda_check, .sda_low_req, .scl_low_req,
    .byte_done, .ack_done, .serial_status_reg, .serial_event_flag,
    .event_irq, .bus_collision_flag, .lost_phase, .bus_free,
    .master_active, .scl_in(scl), .sda_in(sda), .scl_out, .scl_oe_n,
    .sda_out, .sda_oe_n);
  bus_peer peer (.link_clk, .scl, .sda, .scl_low(peer_scl),
    .sda_low(peer_sda));
  // =====================================
  // helpers
  task automatic chk_bit(input logic got, input logic exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("mismatch at %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // =====================================
  // scenarios
  task automatic t_reset();
    chk_byte(serial_status_reg, `STAT_RESET);
    chk_bit(bus_free, 1'b1);
    chk_bit(sda_oe_n & scl_oe_n, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_events();
    peer.drive_sda(1'b1);
    cyc(40);
    chk_byte(serial_status_reg, 8'h08);
    chk_bit(bus_free, 1'b0);
    chk_bit(serial_event_flag, 1'b1);
    event_clear = 1'b1;
    cyc(1);
    event_clear = 1'b0;
    event_enable = 1'b1;
    cyc(2);
    chk_bit(event_irq, 1'b0);
    peer.drive_sda(1'b0);
    cyc(40);
    chk_byte(serial_status_reg, 8'h10);
    chk_bit(event_irq, 1'b1);
    chk_bit(bus_free, 1'b1);
    event_clear = 1'b1;
    cyc(1);
    event_clear = 1'b0;
    chk_bit(serial_event_flag, 1'b0);
    byte_done = 1'b1;
    cyc(1);
    byte_done = 1'b0;
    cyc(2);
    chk_bit(serial_event_flag, 1'b1);
    event_clear = 1'b1;
    cyc(1);
    event_clear = 1'b0;
    chk_bit(serial_event_flag, 1'b0);
    ack_done = 1'b1;
    cyc(1);
    ack_done = 1'b0;
    cyc(2);
    chk_bit(serial_event_flag, 1'b1);
    $display("test events done");
  endtask
  task automatic t_disable();
    port_enable_bit = 1'b0;
    cyc(2);
    chk_byte(serial_status_reg, `STAT_RESET);
    master_go = 1'b1;
    cyc(1);
    master_go = 1'b0;
    scl_low_req = 1'b1;
    cyc(20);
    chk_bit(scl_oe_n, 1'b1);
    chk_bit(master_active, 1'b0);
    scl_low_req = 1'b0;
    port_enable_bit = 1'b1;
    cyc(2);
    $display("test disable done");
  endtask
  task automatic t_drive();
    master_go = 1'b1;
    cyc(1);
    master_go = 1'b0;
    cyc(1);
    chk_bit(master_active, 1'b1);
    scl_low_req = 1'b1;
    cyc(20);
    sda_low_req = 1'b1;
    cyc(20);
    chk_bit(scl_oe_n | sda_oe_n, 1'b0);
    chk_bit(scl_out | sda_out, 1'b0);
    sda_low_req = 1'b0;
    cyc(20);
    scl_low_req = 1'b0;
    cyc(20);
    master_done = 1'b1;
    cyc(1);
    master_done = 1'b0;
    cyc(2);
    chk_bit(master_active, 1'b0);
    $display("test drive done");
  endtask
  task automatic t_loss();
    op_phase_e ph;
    for (int p = 1; p <= 5; p++) begin
      ph = op_phase_e'(p);
      master_go = 1'b1;
      phase = ph;
      sda_check = 1'b1;
      cyc(1);
      master_go = 1'b0;
      peer.drive_sda(1'b1);
      cyc(40);
      chk_bit(bus_collision_flag, 1'b1);
      chk_byte(8'(lost_phase), 8'(ph));
      chk_bit(master_active, 1'b0);
      sda_check = 1'b0;
      scl_low_req = 1'b1;
      cyc(20);
      chk_bit(scl_oe_n, 1'b1);
      scl_low_req = 1'b0;
      collision_clear = 1'b1;
      cyc(1);
      collision_clear = 1'b0;
      peer.drive_sda(1'b0);
      cyc(20);
      chk_bit(bus_collision_flag, 1'b0);
    end
    $display("test loss done");
  endtask
  // =====================================
  // clocks, sequence and watchdog
  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end
  // link clock deliberately offset from the system clock; its first
  // rise comes early so the link side sees reset three times
  initial begin
    link_clk = 1'b0;
    #7;
    forever begin
      link_clk = ~link_clk;
      #62.5;
    end
  end
  initial begin
    rst = 1'b1;
    {port_enable_bit, event_enable, event_clear, collision_clear} = 4'h0;
    {master_go, master_done, sda_check, sda_low_req} = 4'h0;
    {scl_low_req, byte_done, ack_done} = 3'h0;
    phase = PH_NONE;
    cyc(12);
    rst = 1'b0;
    port_enable_bit = 1'b1;
    cyc(20);
    t_reset();
    t_events();
    t_disable();
    t_drive();
    t_loss();
    report_and_stop();
  end
  initial begin
    #200000;
    miscompares++;
    report_and_stop();
  end
endmodule

// *** verilog/arb_defines.svh ***
// bit positions and event indices shared by the bus supervisor files
// assumes it is included by bare name after the package it sits beside
`ifndef ARB_DEFINES_SVH
`define ARB_DEFINES_SVH

// event toggle indices, link domain to system domain
`define EV_START 0
`define EV_STOP 1
`define EV_LOSS 2
`define EV_W 3

// status byte layout
`define STAT_W 8
`define STAT_START_BIT 3
`define STAT_STOP_BIT 4
`define STAT_RESET 8'h00

// synchroniser input width in the link domain
`define LINK_IN_W 6

`endif

// *** verilog/arb_pkg.sv ***
// types for the multi-master bus supervisor
// assumes nothing beyond a SystemVerilog compiler
package arb_pkg;

  // which part of a master operation is on the wires
  typedef enum logic [2:0] {
    PH_NONE, PH_START, PH_RSTART, PH_ADDR, PH_DATA, PH_ACK
  } op_phase_e;

  // master operation state
  typedef enum logic [1:0] {M_IDLE, M_RUN, M_LOST} master_e;

endpackage

// *** verilog/bus_supervisor.sv ***
// multi-master supervisor: start/stop flags, bus-free status, event
// flag, collision flag and master abandon on lost arbitration
// assumes a byte engine on clock supplies phase and drive requests,
// and the wires are pulled up outside; link_clk is unrelated to clock
`timescale 1ns/1ps
`include "arb_defines.svh"
module bus_supervisor
  import arb_pkg::*;
(
  // clocks and reset
  input wire logic clock,
  input wire logic rst,
  input wire logic link_clk,
  // control from firmware
  input wire logic port_enable_bit,
  input wire logic event_enable,
  input wire logic event_clear,
  input wire logic collision_clear,
  // byte engine
  input wire logic master_go,
  input wire logic master_done,
  input wire op_phase_e phase,
  input wire logic sda_check,
  input wire logic sda_low_req,
  input wire logic scl_low_req,
  input wire logic byte_done,
  input wire logic ack_done,
  // status
  output logic [`STAT_W-1:0] serial_status_reg,
  output logic serial_event_flag,
  output logic event_irq,
  output logic bus_collision_flag,
  output op_phase_e lost_phase,
  output logic bus_free,
  output logic master_active,
  // wires
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n
);

  lw_if lw ();

  line_watch u_watch (
    .link_clk(link_clk),
    .rst(rst),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .scl_out(scl_out),
    .scl_oe_n(scl_oe_n),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .lw(lw)
  );

  // ==========================================================
  // event crossing: toggles, two flops, then an edge
  logic [`EV_W-1:0] tog_m, tog_s, tog_p;
  logic [`EV_W-1:0] ev;
  logic ev_start, ev_stop, ev_loss;

  always_ff @(posedge clock) begin
    if (rst) begin
      tog_m <= '0;
      tog_s <= '0;
      tog_p <= '0;
    end else begin
      tog_m <= lw.tog;
      tog_s <= tog_m;
      tog_p <= tog_s;
    end
  end

  // a disabled port ignores the bus entirely
  assign ev = (tog_s ^ tog_p) & {`EV_W{port_enable_bit}};
  assign ev_start = ev[`EV_START];
  assign ev_stop = ev[`EV_STOP];
  assign ev_loss = ev[`EV_LOSS];

  // ==========================================================
  // flags and master state
  logic start_flag, stop_flag;
  logic next_start_flag, next_stop_flag;
  logic next_event_flag, next_irq, next_coll;
  logic next_bus_free, next_active;
  logic [`STAT_W-1:0] next_status;
  op_phase_e next_lost_phase;
  master_e mstate, next_mstate;
  logic next_sda_low, next_scl_low, next_check;

  always_comb begin
    next_start_flag = start_flag;
    next_stop_flag = stop_flag;
    if (!port_enable_bit) begin
      next_start_flag = 1'b0;
      next_stop_flag = 1'b0;
    end else if (ev_start) begin
      next_start_flag = 1'b1;
      next_stop_flag = 1'b0;
    end else if (ev_stop) begin
      next_start_flag = 1'b0;
      next_stop_flag = 1'b1;
    end

    // bus free after a STOP, or when nothing has been seen yet
    next_bus_free = next_stop_flag | ~next_start_flag;

    next_status = `STAT_RESET;
    next_status[`STAT_START_BIT] = next_start_flag;
    next_status[`STAT_STOP_BIT] = next_stop_flag;

    // set wins over a clear in the same cycle
    next_event_flag = (serial_event_flag & ~event_clear) |
      ev_start | ev_stop |
      (port_enable_bit & (byte_done | ack_done));
    // a late enable still fires at once on a flag already pending
    next_irq = next_event_flag & event_enable;

    next_coll = (bus_collision_flag & ~collision_clear) |
      ev_loss;
    next_lost_phase = lost_phase;

    next_mstate = mstate;
    unique case (mstate)
      M_IDLE: begin
        if (port_enable_bit && master_go) begin
          next_mstate = M_RUN;
        end
      end
      M_RUN: begin
        if (ev_loss) begin
          next_mstate = M_LOST;
          next_lost_phase = phase;
        end else if (master_done) begin
          next_mstate = M_IDLE;
        end
      end
      M_LOST: begin
        // only a fresh go from firmware restarts
        if (master_go) begin
          next_mstate = M_RUN;
        end
      end
      default: begin
        // the unused code falls back to idle
        next_mstate = M_IDLE;
      end
    endcase
    if (!port_enable_bit) begin
      next_mstate = M_IDLE;
    end

    next_active = (next_mstate == M_RUN);
    next_check = next_active & sda_check;
    next_sda_low = next_active & sda_low_req;
    next_scl_low = next_active & scl_low_req;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      start_flag <= 1'b0;
      stop_flag <= 1'b0;
      serial_status_reg <= `STAT_RESET;
      serial_event_flag <= 1'b0;
      event_irq <= 1'b0;
      bus_collision_flag <= 1'b0;
      lost_phase <= PH_NONE;
      bus_free <= 1'b1;
      mstate <= M_IDLE;
      master_active <= 1'b0;
      lw.enable <= 1'b0;
      lw.active <= 1'b0;
      lw.check <= 1'b0;
      lw.sda_low <= 1'b0;
      lw.scl_low <= 1'b0;
    end else begin
      start_flag <= next_start_flag;
      stop_flag <= next_stop_flag;
      serial_status_reg <= next_status;
      serial_event_flag <= next_event_flag;
      event_irq <= next_irq;
      bus_collision_flag <= next_coll;
      lost_phase <= next_lost_phase;
      bus_free <= next_bus_free;
      mstate <= next_mstate;
      master_active <= next_active;
      lw.enable <= port_enable_bit;
      lw.active <= next_active;
      lw.check <= next_check;
      lw.sda_low <= next_sda_low;
      lw.scl_low <= next_scl_low;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_disable_clears: assert property (
    !port_enable_bit |=> serial_status_reg == `STAT_RESET)
    else $error("start or stop flag kept while disabled");
  a_busy_not_free: assert property (
    ev_start |=> !bus_free && serial_status_reg[`STAT_START_BIT])
    else $error("bus reported free after a START");
  a_stop_frees_bus: assert property (
    ev_stop && !ev_start |=> bus_free &&
    serial_status_reg[`STAT_STOP_BIT])
    else $error("bus not free after a STOP");
  a_cond_event: assert property (
    (ev_start || ev_stop) |=> serial_event_flag)
    else $error("no event flag on START or STOP");
  a_stop_irq: assert property (
    ev_stop && event_enable |=> event_irq)
    else $error("enabled interrupt missing on STOP");
  a_loss_flag: assert property (
    ev_loss |=> bus_collision_flag ##1
    (bus_collision_flag || $past(collision_clear)))
    else $error("collision not recorded");
  a_loss_phase: assert property (
    ev_loss && mstate == M_RUN |=>
    lost_phase == $past(phase) && mstate == M_LOST)
    else $error("lost phase not captured");
  a_byte_event: assert property (
    port_enable_bit && (byte_done || ack_done) |=>
    serial_event_flag)
    else $error("no event flag on byte or ack");
  a_master_abandon: assert property (
    ev_loss && mstate == M_RUN && !master_go |=>
    !master_active && !lw.sda_low && !lw.scl_low ##1
    (mstate == M_LOST || $past(master_go) ||
    !$past(port_enable_bit)))
    else $error("master kept running after loss");
  a_enable_link: assert property (
    !port_enable_bit |=> !lw.enable && !lw.active)
    else $error("link enabled while port off");

endmodule

// *** verilog/line_watch.sv ***
// link-side logic: samples the two wires, spots START, STOP and lost
// arbitration, and drives the open-drain pins
// assumes link_clk is free running and rst comes from the system domain
`timescale 1ns/1ps
`include "arb_defines.svh"
module line_watch
  import arb_pkg::*;
(
  // clock and reset
  input wire logic link_clk,
  input wire logic rst,
  // wires
  input wire logic scl_in,
  input wire logic sda_in,
  output logic scl_out,
  output logic scl_oe_n,
  output logic sda_out,
  output logic sda_oe_n,
  // supervisor side
  lw_if.link lw
);

  // ==========================================================
  // reset and input synchronisers
  logic [1:0] rst_sync;
  logic link_rst;
  logic [`LINK_IN_W-1:0] in_m;
  logic [`LINK_IN_W-1:0] in_s;
  logic scl_s, sda_s, en_s, chk_s, sdl_s, scll_s;

  always_ff @(posedge link_clk) begin
    rst_sync <= {rst_sync[0], rst};
  end
  assign link_rst = rst_sync[1];
  assign {scl_s, sda_s, en_s, chk_s, sdl_s, scll_s} = in_s;

  // active rides with the drive requests; it gates the pin drive, loss detection and the lost latch
  logic act_m, act_q;

  // ==========================================================
  // line state
  logic scl_p, sda_p, lost;
  logic [`EV_W-1:0] tog;
  logic next_scl_p, next_sda_p, next_lost;
  logic next_sda_oe_n, next_scl_oe_n;
  logic [`EV_W-1:0] next_tog;
  logic [`EV_W-1:0] ev_now;

  always_comb begin
    ev_now = '0;
    ev_now[`EV_START] = scl_s & scl_p & sda_p & ~sda_s;
    ev_now[`EV_STOP] = scl_s & scl_p & ~sda_p & sda_s;
    // released SDA but the wire reads low while SCL is high
    ev_now[`EV_LOSS] = en_s & act_q & chk_s & ~sdl_s & ~lost &
      scl_s & scl_p & ~sda_s;
    next_scl_p = scl_s;
    next_sda_p = sda_s;
    next_tog = tog ^ ev_now;
    // hold off both lines until the supervisor drops active
    next_lost = en_s & act_q & (lost | ev_now[`EV_LOSS]);
    next_sda_oe_n = ~(en_s & act_q & sdl_s & ~next_lost);
    next_scl_oe_n = ~(en_s & act_q & scll_s & ~next_lost);
  end

  always_ff @(posedge link_clk) begin
    if (link_rst) begin
      in_m <= '0;
      in_s <= '0;
      act_m <= 1'b0;
      act_q <= 1'b0;
      scl_p <= 1'b1;
      sda_p <= 1'b1;
      lost <= 1'b0;
      tog <= '0;
      sda_oe_n <= 1'b1;
      scl_oe_n <= 1'b1;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end else begin
      in_m <= {scl_in, sda_in, lw.enable, lw.check, lw.sda_low,
               lw.scl_low};
      in_s <= in_m;
      act_m <= lw.active;
      act_q <= act_m;
      scl_p <= next_scl_p;
      sda_p <= next_sda_p;
      lost <= next_lost;
      tog <= next_tog;
      sda_oe_n <= next_sda_oe_n;
      scl_oe_n <= next_scl_oe_n;
      sda_out <= 1'b0;
      scl_out <= 1'b0;
    end
  end
  assign lw.tog = tog;

  // ==========================================================
  // checks
  a_disabled_release: assert property (@(posedge link_clk)
    disable iff (link_rst) !en_s |=> sda_oe_n && scl_oe_n)
    else $error("pins driven while port disabled");
  a_loss_release: assert property (@(posedge link_clk)
    disable iff (link_rst)
    ev_now[`EV_LOSS] |=> sda_oe_n && scl_oe_n && lost)
    else $error("lines still driven after lost arbitration");

endmodule

// *** verilog/lw_if.sv ***
// carrier between the system-clock supervisor and the link-side watcher
// assumes each side registers what it drives; no clock travels here
`timescale 1ns/1ps
`include "arb_defines.svh"
interface lw_if;
  logic enable;
  logic active;
  logic check;
  logic sda_low;
  logic scl_low;
  logic [`EV_W-1:0] tog;

  modport main (output enable, active, check, sda_low, scl_low,
                input tog);
  modport link (input enable, active, check, sda_low, scl_low,
                output tog);
endinterface
